/* File: design/ppc_defines.svh */
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_ADDR_CTRL 5'h19
`define PPC_ADDR_TALLY 5'h1b
`define PPC_ADDR_IRQ_STAT 5'h1c
`define PPC_ADDR_IRQ_MASK 5'h1d
`define PPC_ADDR_ADVERT 5'h1e
`define PPC_BIT_AUTOX 15
`define PPC_BIT_FORCEX 14
`define PPC_BIT_PAUSE_RX 13
`define PPC_BIT_PAUSE_TX 12
`define PPC_BIT_FORCE_ERR 11
`define PPC_BIT_SEQ_SEL 10
`define PPC_BIT_PASS 9
`define PPC_BIT_RUN 8
`define PPC_BIT_BYPASS 7
`define PPC_STRETCH_NS 32'd40000000
`define PPC_CLK_NS 32'd20
`define PPC_STRETCH_CYC (`PPC_STRETCH_NS / `PPC_CLK_NS)
`define PPC_BLINK_NS 32'd83000000
`define PPC_BLINK_CYC (`PPC_BLINK_NS / `PPC_CLK_NS)
`endif

/* File: design/ppc_pkg.sv */
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_IDLE = 2'h0,
    PPC_RUN = 2'h1,
    PPC_FAIL = 2'h3
  } ppc_test_e;
  typedef struct packed {
    logic auto_crossover_enable;
    logic force_pair_crossover;
    logic selftest_force_error;
    logic selftest_sequence_select;
    logic selftest_run;
    logic indicator_stretch_bypass;
    logic [1:0] indicator_mode_select;
    logic [4:0] port_management_address;
    ppc_test_e test_state;
    logic [7:0] selftest_error_tally;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] local_ab;
    logic [3:0] partner_ab;
    logic [15:0] rdata;
    logic irq;
    logic pause_rx;
    logic pause_tx;
    logic link_ind;
    logic speed_ind;
    logic actcol_ind;
    logic mdi_swap;
    logic autox_active;
    logic inject_err;
    logic [1:0] link_s1;
    logic [1:0] link_s2;
    logic [31:0] act_cnt;
    logic [31:0] col_cnt;
    logic [31:0] blink_cnt;
    logic blink_ph;
    logic err_s1;
    logic err_s2;
    logic act_s1;
    logic act_s2;
    logic col_s1;
    logic col_s2;
    logic dup_s1;
    logic dup_s2;
  } ppc_state_s;
endpackage : ppc_pkg

/* File: design/ppc_port_control.sv */
// Summary of operation
// - Auto crossover enable turns automatic pair crossover on during auto-negotiation, unless force crossover is set.
// - Force crossover swaps the transmit and receive pairs; it resets to zero.
// - Pause receive is resolved from the advert bits and only for full duplex.
// - Pause transmit follows the standard pause resolution, only for full duplex.
// - Writing one to force error while run is set injects exactly one error, then the bit self clears.
// - Bit 8 runs the self test, bit 10 picks the sequence, bit 9 reads pass and drops once a fail latches until stop.
// - Stretch bypass drives the indicators straight from internal status.
// - Mode field bits 6:5 choose mode 1, 2 or 3 and default from straps.
// - Mode 1 shows link, speed and activity.
// - Mode 2 shows link blinking on activity, speed, and collision.
// - Mode 3 shows link blinking on activity, speed, and duplex.
// - A five bit strap defaulted writable field holds the management address.
// - The error tally counts errored nibbles, clears on restart and sticks at max.
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defines.svh"
module ppc_port_control (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic strap_auto_crossover,
  input wire logic [1:0] strap_indicator_mode,
  input wire logic [4:0] strap_address,
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic activity,
  input wire logic collision,
  input wire logic nibble_error,
  output logic link_indicator,
  output logic speed_indicator,
  output logic activity_collision_indicator,
  output logic pair_swap,
  output logic auto_crossover_active,
  output logic inject_error,
  output logic selftest_run,
  output logic selftest_sequence_select,
  output logic [4:0] port_management_address
);
  ppc_pkg::ppc_state_s s_reg, s_next;
  logic strap_load_reg;
  logic ctl_hit;
  logic [15:0] ctl_word;
  logic test_fail;
  logic [3:0] ev;

  // Straps are caught by a clocked load on the first edge after reset release.
  always_ff @(posedge ref_clk) begin
    strap_load_reg <= ~nrst;
  end

  assign ctl_hit = reg_wr && (reg_addr == `PPC_ADDR_CTRL);
  assign test_fail = s_reg.test_state == ppc_pkg::PPC_FAIL;

  always_comb begin
    ctl_word = {s_reg.auto_crossover_enable, s_reg.force_pair_crossover, s_reg.pause_rx,
                s_reg.pause_tx, s_reg.selftest_force_error, s_reg.selftest_sequence_select,
                s_reg.selftest_run && !test_fail, s_reg.selftest_run,
                s_reg.indicator_stretch_bypass, s_reg.indicator_mode_select,
                s_reg.port_management_address};
  end

  always_comb begin
    logic rx_pause;
    logic tx_pause;
    logic lsym, lasym, psym, pasym;
    logic link_raw, act_raw, col_raw, act_v, col_v, blink_link;
    rx_pause = 1'b0;
    tx_pause = 1'b0;
    lsym = 1'b0;
    lasym = 1'b0;
    psym = 1'b0;
    pasym = 1'b0;
    link_raw = 1'b0;
    act_raw = 1'b0;
    col_raw = 1'b0;
    act_v = 1'b0;
    col_v = 1'b0;
    blink_link = 1'b0;
    s_next = s_reg;
    // Duplex comes from the line side like every other status pin, so it is synchronised too.
    s_next.dup_s1 = full_duplex;
    s_next.dup_s2 = s_reg.dup_s1;
    s_next.link_s1 = {speed_100, link_good};
    s_next.link_s2 = s_reg.link_s1;
    s_next.err_s1 = nibble_error;
    s_next.err_s2 = s_reg.err_s1;
    s_next.act_s1 = activity;
    s_next.act_s2 = s_reg.act_s1;
    s_next.col_s1 = collision;
    s_next.col_s2 = s_reg.col_s1;
    ev = 4'h0;
    if (strap_load_reg) begin
      s_next.auto_crossover_enable = strap_auto_crossover;
      s_next.indicator_mode_select = strap_indicator_mode;
      s_next.port_management_address = strap_address;
    end
    // Self clear after one cycle so exactly one error is injected.
    s_next.selftest_force_error = 1'b0;
    s_next.inject_err = s_reg.selftest_force_error && s_reg.selftest_run;
    if (s_reg.selftest_run && s_reg.err_s2) begin
      s_next.test_state = ppc_pkg::PPC_FAIL;
      if (s_reg.selftest_error_tally != 8'hff) begin
        s_next.selftest_error_tally = s_reg.selftest_error_tally + 8'h01;
      end
    end
    if (ctl_hit) begin
      s_next.auto_crossover_enable = reg_wdata[`PPC_BIT_AUTOX];
      s_next.force_pair_crossover = reg_wdata[`PPC_BIT_FORCEX];
      s_next.selftest_force_error = reg_wdata[`PPC_BIT_FORCE_ERR];
      s_next.selftest_sequence_select = reg_wdata[`PPC_BIT_SEQ_SEL];
      s_next.selftest_run = reg_wdata[`PPC_BIT_RUN];
      s_next.indicator_stretch_bypass = reg_wdata[`PPC_BIT_BYPASS];
      s_next.indicator_mode_select = reg_wdata[6:5];
      s_next.port_management_address = reg_wdata[4:0];
      if (reg_wdata[`PPC_BIT_RUN] && !s_reg.selftest_run) begin
        s_next.selftest_error_tally = 8'h00;
        s_next.test_state = ppc_pkg::PPC_RUN;
      end else if (!reg_wdata[`PPC_BIT_RUN]) begin
        s_next.test_state = ppc_pkg::PPC_IDLE;
      end
    end
    if (reg_wr && reg_addr == `PPC_ADDR_IRQ_MASK) s_next.irq_mask = reg_wdata[3:0];
    if (reg_wr && reg_addr == `PPC_ADDR_ADVERT) begin
      s_next.local_ab = reg_wdata[3:0];
      s_next.partner_ab = reg_wdata[7:4];
    end
    // Advert bit 0 is symmetric pause, bit 1 asymmetric, bit 2 full duplex common mode.
    lsym = s_reg.local_ab[0];
    lasym = s_reg.local_ab[1];
    psym = s_reg.partner_ab[0];
    pasym = s_reg.partner_ab[1];
    if (s_reg.local_ab[2] && s_reg.partner_ab[2]) begin
      rx_pause = (lsym && psym) || (lsym && lasym && !psym && pasym);
      tx_pause = (lsym && psym) || (!lsym && lasym && psym && pasym);
    end
    s_next.pause_rx = rx_pause;
    s_next.pause_tx = tx_pause;
    s_next.mdi_swap = s_reg.force_pair_crossover;
    s_next.autox_active = s_reg.auto_crossover_enable && !s_reg.force_pair_crossover;
    link_raw = s_reg.link_s2[0];
    act_raw = s_reg.act_s2;
    col_raw = s_reg.col_s2;
    s_next.act_cnt = act_raw ? `PPC_STRETCH_CYC : (s_reg.act_cnt != 32'd0 ?
                     s_reg.act_cnt - 32'd1 : 32'd0);
    s_next.col_cnt = col_raw ? `PPC_STRETCH_CYC : (s_reg.col_cnt != 32'd0 ?
                     s_reg.col_cnt - 32'd1 : 32'd0);
    // Bypass trades visibility of short events for an exact view of internal state.
    act_v = s_reg.indicator_stretch_bypass ? act_raw : (s_reg.act_cnt != 32'd0);
    col_v = s_reg.indicator_stretch_bypass ? col_raw : (s_reg.col_cnt != 32'd0);
    if (s_reg.blink_cnt >= `PPC_BLINK_CYC) begin
      s_next.blink_cnt = 32'd0;
      s_next.blink_ph = !s_reg.blink_ph;
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 32'd1;
    end
    blink_link = link_raw && !(act_v && s_reg.blink_ph);
    s_next.speed_ind = s_reg.link_s2[1];
    case (s_reg.indicator_mode_select)
      2'h1, 2'h3: begin
        s_next.link_ind = link_raw;
        s_next.actcol_ind = act_v;
      end
      2'h0: begin
        s_next.link_ind = blink_link;
        s_next.actcol_ind = col_v;
      end
      2'h2: begin
        s_next.link_ind = blink_link;
        s_next.actcol_ind = s_reg.dup_s2;
      end
      default: begin
        s_next.link_ind = link_raw;
        s_next.actcol_ind = 1'b0;
      end
    endcase
    ev[0] = s_reg.selftest_run && s_reg.err_s2 && !test_fail;
    ev[1] = s_reg.link_s2[0] != s_reg.link_s1[0];
    ev[2] = rx_pause != s_reg.pause_rx;
    ev[3] = s_reg.inject_err;
    if (reg_rd && reg_addr == `PPC_ADDR_IRQ_STAT) s_next.irq_stat = 4'h0;
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    case (reg_addr)
      `PPC_ADDR_CTRL: s_next.rdata = ctl_word;
      `PPC_ADDR_TALLY: s_next.rdata = {s_reg.selftest_error_tally, 8'h00};
      `PPC_ADDR_IRQ_STAT: s_next.rdata = {12'h000, s_reg.irq_stat};
      `PPC_ADDR_IRQ_MASK: s_next.rdata = {12'h000, s_reg.irq_mask};
      `PPC_ADDR_ADVERT: s_next.rdata = {8'h00, s_reg.partner_ab, s_reg.local_ab};
      default: s_next.rdata = 16'h0000;
    endcase
    if (!reg_rd) s_next.rdata = 16'h0000;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign link_indicator = s_reg.link_ind;
  assign speed_indicator = s_reg.speed_ind;
  assign activity_collision_indicator = s_reg.actcol_ind;
  assign pair_swap = s_reg.mdi_swap;
  assign auto_crossover_active = s_reg.autox_active;
  assign inject_error = s_reg.inject_err;
  assign selftest_run = s_reg.selftest_run;
  assign selftest_sequence_select = s_reg.selftest_sequence_select;
  assign port_management_address = s_reg.port_management_address;

  a_force_err_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.selftest_force_error |=> !s_reg.selftest_force_error) else $error("force error stuck");
  a_inject_once: assert property (@(posedge ref_clk) disable iff (!nrst)
    inject_error |=> !inject_error) else $error("error injected twice");
  a_swap_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit ##1 1'b1 |=> pair_swap == $past(reg_wdata[14], 2)) else $error("swap wrong");
  a_autox_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    auto_crossover_active |-> $past(s_reg.auto_crossover_enable)) else $error("autox");
  a_pause_duplex: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(s_reg.local_ab[2] && s_reg.partner_ab[2]) |=> !s_reg.pause_rx) else $error("pause rx");
  a_pause_tx_dup: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(s_reg.local_ab[2] && s_reg.partner_ab[2]) |=> !s_reg.pause_tx) else $error("pause tx");
  a_fail_latches: assert property (@(posedge ref_clk) disable iff (!nrst)
    test_fail && !ctl_hit |=> test_fail) else $error("fail not latched");
  a_tally_sticks: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.selftest_error_tally == 8'hff && !ctl_hit |=> s_reg.selftest_error_tally == 8'hff)
    else $error("tally wrapped");
  a_mode3_duplex: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.indicator_mode_select == 2'h2 |=> activity_collision_indicator == $past(s_reg.dup_s2))
    else $error("mode 3 duplex");
  a_strap_addr: assert property (@(posedge ref_clk)
    strap_load_reg && nrst |=> port_management_address == $past(strap_address))
    else $error("strap address");
  // Read data stands for one cycle after each cycle that reg_rd is high; any other cycle the bus reads as zero.
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == 5'h00 |=> reg_rdata == 16'h0000) else $error("unmapped read");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |-> irq == |(s_reg.irq_stat & s_reg.irq_mask)) else $error("irq level");
  // A status event in the same cycle as the clearing read must survive the read.
  a_stat_set_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev != 4'h0 |=> (s_reg.irq_stat & $past(ev)) == $past(ev)) else $error("event lost");
  a_stat_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == `PPC_ADDR_IRQ_STAT && ev == 4'h0 |=> s_reg.irq_stat == 4'h0)
    else $error("status not cleared");
  a_autox_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit |=> s_reg.auto_crossover_enable == $past(reg_wdata[15])) else $error("autox wr");
  a_seq_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit |=> selftest_sequence_select == $past(reg_wdata[10])) else $error("seq wr");
  a_run_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit |=> selftest_run == $past(reg_wdata[8])) else $error("run wr");
  a_pass_on_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit && !reg_wdata[8] |=> !test_fail) else $error("fail kept after stop");
  a_tally_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit && reg_wdata[8] && !s_reg.selftest_run |=> s_reg.selftest_error_tally == 8'h00)
    else $error("tally not reset");
  a_inject_run: assert property (@(posedge ref_clk) disable iff (!nrst)
    inject_error |-> $past(s_reg.selftest_run)) else $error("inject while idle");
  a_addr_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctl_hit |=> port_management_address == $past(reg_wdata[4:0])) else $error("addr wr");
  // Speed passes two synchroniser stages and the output register, three cycles in all.
  a_speed_path: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> ##2 speed_indicator == $past(speed_100, 3)) else $error("speed path");
  a_mode1_link: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.indicator_mode_select[0] |=> link_indicator == $past(s_reg.link_s2[0]))
    else $error("mode 1 link");
  a_bypass_act: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.indicator_mode_select[0] && s_reg.indicator_stretch_bypass
    |=> activity_collision_indicator == $past(s_reg.act_s2)) else $error("bypass act");
  a_mode2_col: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.indicator_mode_select == 2'h0 && s_reg.indicator_stretch_bypass
    |=> activity_collision_indicator == $past(s_reg.col_s2)) else $error("mode 2 col");
  // The stretch keeps a short burst of activity visible for the whole hold time.
  a_stretch_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_reg.indicator_mode_select[0] && !s_reg.indicator_stretch_bypass && s_reg.act_cnt != 32'd0
    |=> activity_collision_indicator) else $error("stretch dropped");
  c_selftest_fail: cover property (@(posedge ref_clk) disable iff (!nrst) s_reg.selftest_run ##1 test_fail);
  c_irq_raise: cover property (@(posedge ref_clk) disable iff (!nrst) !irq ##1 irq);
  c_pause_both: cover property (@(posedge ref_clk) disable iff (!nrst) s_reg.pause_rx && s_reg.pause_tx);
  c_inject: cover property (@(posedge ref_clk) disable iff (!nrst) inject_error);
  c_mode3: cover property (@(posedge ref_clk) disable iff (!nrst) s_reg.indicator_mode_select == 2'h2);
endmodule : ppc_port_control
`default_nettype wire

/* File: verification/ppc_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stands in for the line side: status levels commanded by the bench, and a
// self-test stream that shows every injected error as one errored nibble.
module ppc_line_model (
  input wire logic ref_clk,
  input wire logic [4:0] cfg,
  input wire logic burst,
  input wire logic inject_error,
  output logic link_good,
  output logic speed_100,
  output logic full_duplex,
  output logic activity,
  output logic collision,
  output logic nibble_error
);
  logic inj_q;
  initial inj_q = 1'b0;
  always @(posedge ref_clk) inj_q <= inject_error;
  assign {link_good, speed_100, full_duplex, activity, collision} = cfg;
  assign nibble_error = burst | inj_q;
endmodule : ppc_line_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, burst = 1'b0, rd_q = 1'b0;
  logic [4:0] reg_addr = 5'h00, cfg = 5'h00, s_adr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, ctl;
  logic [1:0] s_mode = 2'h0;
  logic s_ax = 1'b0, irq, lnk, spd, acc, swp, axa, inj, run, seq;
  logic [4:0] adr;
  logic lg, sp, fd, ac, co, ne;
  logic [15:0] q_v[$], q_m[$];
  int err_total = 0, n_compared = 0, inj_n = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  ppc_port_control u_ppc_port_control (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .strap_auto_crossover(s_ax), .strap_indicator_mode(s_mode), .strap_address(s_adr),
    .link_good(lg), .speed_100(sp), .full_duplex(fd), .activity(ac), .collision(co),
    .nibble_error(ne), .link_indicator(lnk), .speed_indicator(spd),
    .activity_collision_indicator(acc), .pair_swap(swp), .auto_crossover_active(axa),
    .inject_error(inj), .selftest_run(run), .selftest_sequence_select(seq),
    .port_management_address(adr));
  ppc_line_model u_ppc_line_model (.ref_clk(ref_clk), .cfg(cfg), .burst(burst),
    .inject_error(inj), .link_good(lg), .speed_100(sp), .full_duplex(fd), .activity(ac),
    .collision(co), .nibble_error(ne));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (inj === 1'b1) inj_n++;
    if (rd_q) chk("reg_rdata", q_v.pop_front(), reg_rdata & q_m.pop_front());
    rd_q <= reg_rd;
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Expectations are noted at issue; the monitor pairs them with data in order.
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q_v.push_back(e & m);
    q_m.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  initial begin
    logic l_s, l_a, l_f, p_s, p_a, p_f, tx, rx;
    void'($urandom(26460));
    s_ax <= 1'($urandom());
    s_mode <= 2'($urandom());
    s_adr <= 5'($urandom());
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ctl = {s_ax, 8'h00, 2'(s_mode), 5'(s_adr)};
    rd(5'h19, ctl, 16'hffff);
    chk("port_management_address", 16'(s_adr), 16'(adr));
    chk("auto_crossover_active", 16'(s_ax), 16'(axa));
    rd(5'h00, 16'h0000, 16'hffff);
    ctl = {2'b01, 6'h00, 1'b0, 2'(s_mode), 5'($urandom())};
    wr(5'h19, ctl | 16'h3200);
    repeat (2) @(posedge ref_clk);
    rd(5'h19, ctl, 16'hffff);
    chk("pair_swap", 16'h0001, 16'(swp));
    chk("auto_crossover_active", 16'h0000, 16'(axa));
    chk("port_management_address", 16'(ctl[4:0]), 16'(adr));
    for (int m = 0; m < 4; m++) begin
      ctl = {8'h00, 1'b1, 2'(m), 5'(ctl[4:0])};
      wr(5'h19, ctl);
      for (int k = 0; k < 4; k++) begin
        cfg <= 5'($urandom()) & ((m % 2 == 1) ? 5'h1f : 5'h1d);
        repeat (6) @(posedge ref_clk);
        chk("link_indicator", 16'(cfg[4]), 16'(lnk));
        chk("speed_indicator", 16'(cfg[3]), 16'(spd));
        chk("act_col", 16'(m % 2 == 1 ? cfg[1] : (m == 0 ? cfg[0] : cfg[2])), 16'(acc));
      end
    end
    for (int i = 0; i < 64; i++) begin
      {p_f, p_a, p_s, l_f, l_a, l_s} = 6'(i);
      tx = l_f & p_f & ((l_s & p_s) | (~l_s & l_a & p_s & p_a));
      rx = l_f & p_f & ((l_s & p_s) | (l_s & l_a & ~p_s & p_a));
      wr(5'h1e, {9'h000, 3'(i >> 3), 1'b0, 3'(i)});
      repeat (4) @(posedge ref_clk);
      rd(5'h19, {2'b00, rx, tx, 12'h000}, 16'h3000);
    end
    wr(5'h1d, 16'h0000);
    rd(5'h1c, 16'h0000, 16'h0000);
    ctl = 16'h0500;
    wr(5'h19, ctl);
    repeat (4) @(posedge ref_clk);
    chk("run_seq", 16'h0003, {14'h0000, run, seq});
    rd(5'h19, 16'h0700, 16'h0f00);
    wr(5'h19, ctl | 16'h0800);
    repeat (8) @(posedge ref_clk);
    chk("inject_count", 16'h0001, 16'(inj_n));
    rd(5'h19, 16'h0500, 16'h0f00);
    rd(5'h1b, 16'h0100, 16'hff00);
    chk("irq_masked", 16'h0000, 16'(irq));
    wr(5'h1d, 16'h000f);
    repeat (3) @(posedge ref_clk);
    chk("irq_set", 16'h0001, 16'(irq));
    rd(5'h1c, 16'h0009, 16'h0009);
    repeat (3) @(posedge ref_clk);
    chk("irq_clear", 16'h0000, 16'(irq));
    burst <= 1'b1;
    repeat (300) @(posedge ref_clk);
    burst <= 1'b0;
    rd(5'h1b, 16'hff00, 16'hff00);
    wr(5'h19, 16'h0000);
    rd(5'h19, 16'h0000, 16'h0f00);
    wr(5'h19, 16'h0100);
    repeat (4) @(posedge ref_clk);
    rd(5'h19, 16'h0300, 16'h0f00);
    rd(5'h1b, 16'h0000, 16'hff00);
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
